// ### logic/dtc_control.v
`timescale 1ns/100ps
`include "dtc_regs.vh"

// Function
// - Panel vsync polarity 1 gives idle-high output with low sync pulse.
// - Panel vsync polarity 0 gives idle-low output with high sync pulse.
// - Panel hsync polarity bit picks idle level and pulse direction of panel hsync.
// - Crt_vertical_sync_pin polarity bit picks idle level and pulse direction of Crt_vertical_sync_pin.
// - Crt_horizontal_sync_pin polarity bit picks idle level and pulse direction of Crt_horizontal_sync_pin.
// - Blink enable makes cursor and text blink at rate from blink rate select.
// - Rate 0: cursor period 16 frames, 8 on; text period 32, 16 on.
// - Vertical interrupt enable raises interrupt at next vertical sync pulse.
// - Writing vertical interrupt enable 0 disables and clears pending interrupt.
// - Timing generator enable 0 allows timing writes, holds dot-clock logic reset.
// - Timing generator enable 1 runs timing and refuses timing register writes.
// - Data channel clock bit drives Crt_vertical_sync_pin pin while vsync enable is low.
// - Blank enable 0 holds display enable low; 1 outputs composite blank.
// - Crt_horizontal_sync_pin enable 0 holds Crt_horizontal_sync_pin low; 1 outputs generated hsync.
// - Crt_horizontal_sync_pin enable leaves panel hsync to power sequencing control.
// - Crt_vertical_sync_pin enable 0 drives data channel clock bit on Crt_vertical_sync_pin; panel vsync under sequencing.
module dtc_control #(
  parameter TW = 12,
  parameter DOT_DIV = 4
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output wire pslverr_out,
  input wire data_channel_in,
  input wire panel_sync_enable_in,
  output reg crt_vertical_sync_pin_out,
  output reg crt_horizontal_sync_pin_out,
  output reg panel_vsync_out,
  output reg panel_hsync_out,
  output reg display_enable_out,
  output reg cursor_blink_on_out,
  output reg text_blink_on_out,
  output wire irq_out
);

  // ==========================================================
  // Configuration bits
  reg blink_rate_select;
  reg panel_vsync_polarity;
  reg panel_hsync_polarity;
  reg crt_vertical_sync_polarity;
  reg crt_horizontal_sync_polarity;
  reg blink_enable_bit;
  reg vertical_interrupt_enable;
  reg timing_generator_enable;
  reg data_channel_clock_bit;
  reg blank_output_enable;
  reg crt_horizontal_sync_enable;
  reg crt_vertical_sync_enable;
  localparam [31:0] RST_CFG = `DTC_RST_CONFIG;
  localparam [31:0] RST_H = `DTC_RST_H_ACT_TOTAL, RST_HS = `DTC_RST_H_SYNC;
  localparam [31:0] RST_V = `DTC_RST_V_ACT_TOTAL, RST_VS = `DTC_RST_V_SYNC;

  // ==========================================================
  // Timing registers
  reg [TW-1:0] h_active;
  reg [TW-1:0] h_total;
  reg [TW-1:0] h_sync_start;
  reg [TW-1:0] h_sync_end;
  reg [TW-1:0] v_active;
  reg [TW-1:0] v_total;
  reg [TW-1:0] v_sync_start;
  reg [TW-1:0] v_sync_end;

  // ==========================================================
  // Interrupt registers
  reg [`DTC_INT_WIDTH-1:0] int_status;
  reg [`DTC_INT_WIDTH-1:0] int_mask;
  reg [`DTC_INT_WIDTH-1:0] next_int_status;

  // ==========================================================
  // Blink and data channel state
  reg [`DTC_BLINK_CNT_W-1:0] frame_cnt;
  reg ddc_in_q;

  // ==========================================================
  // Bus decode
  wire bus_access = psel_in && penable_in;
  wire bus_write = bus_access && pwrite_in;
  wire is_timing = (paddr_in == `DTC_OFS_H_ACT_TOTAL) || (paddr_in == `DTC_OFS_H_SYNC) ||
                   (paddr_in == `DTC_OFS_V_ACT_TOTAL) || (paddr_in == `DTC_OFS_V_SYNC);
  wire is_mapped = is_timing || (paddr_in == `DTC_OFS_CONFIG) ||
                   (paddr_in == `DTC_OFS_INT_STATUS) || (paddr_in == `DTC_OFS_INT_MASK) ||
                   (paddr_in == `DTC_OFS_STATUS);
  wire timing_write_ok = bus_write && is_timing && !timing_generator_enable;
  wire timing_write_refused = bus_write && is_timing && timing_generator_enable;
  wire cfg_write = bus_write && (paddr_in == `DTC_OFS_CONFIG);
  assign pready_out = 1'b1;
  assign pslverr_out = bus_access && (!is_mapped || timing_write_refused);

  // ==========================================================
  // Dot clock enable divider
  localparam DW = (DOT_DIV > 1) ? $clog2(DOT_DIV) : 1;
  reg [DW-1:0] dot_div_cnt;
  wire dot_en = (dot_div_cnt == DOT_DIV - 1);

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      dot_div_cnt <= {DW{1'b0}};
    end else if (dot_en) begin
      dot_div_cnt <= {DW{1'b0}};
    end else begin
      dot_div_cnt <= dot_div_cnt + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Timing generator
  wire hsync_raw;
  wire vsync_raw;
  wire active_raw;
  wire vsync_start;
  wire frame_end;

  dtc_timing_gen #(
    .TW(TW)
  ) u_timing (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .dot_en_in(dot_en),
    .run_in(timing_generator_enable),
    .h_active_in(h_active),
    .h_total_in(h_total),
    .h_sync_start_in(h_sync_start),
    .h_sync_end_in(h_sync_end),
    .v_active_in(v_active),
    .v_total_in(v_total),
    .v_sync_start_in(v_sync_start),
    .v_sync_end_in(v_sync_end),
    .hsync_out(hsync_raw),
    .vsync_out(vsync_raw),
    .active_out(active_raw),
    .vsync_start_out(vsync_start),
    .frame_end_out(frame_end)
  );

  // ==========================================================
  // Configuration register
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      blink_rate_select <= RST_CFG[`DTC_BIT_BLINK_RATE];
      panel_vsync_polarity <= 1'b0;
      panel_hsync_polarity <= 1'b0;
      crt_vertical_sync_polarity <= 1'b0;
      crt_horizontal_sync_polarity <= 1'b0;
      blink_enable_bit <= 1'b0;
      vertical_interrupt_enable <= 1'b0;
      timing_generator_enable <= 1'b0;
      data_channel_clock_bit <= 1'b0;
      blank_output_enable <= 1'b0;
      crt_horizontal_sync_enable <= 1'b0;
      crt_vertical_sync_enable <= 1'b0;
    end else if (cfg_write) begin
      blink_rate_select <= pwdata_in[`DTC_BIT_BLINK_RATE];
      panel_vsync_polarity <= pwdata_in[`DTC_BIT_PANEL_VSP];
      panel_hsync_polarity <= pwdata_in[`DTC_BIT_PANEL_HSP];
      crt_vertical_sync_polarity <= pwdata_in[`DTC_BIT_CRT_VSP];
      crt_horizontal_sync_polarity <= pwdata_in[`DTC_BIT_CRT_HSP];
      blink_enable_bit <= pwdata_in[`DTC_BIT_BLINK_EN];
      vertical_interrupt_enable <= pwdata_in[`DTC_BIT_VINT_EN];
      timing_generator_enable <= pwdata_in[`DTC_BIT_TIMING_GENERATOR_ENABLE];
      data_channel_clock_bit <= pwdata_in[`DTC_BIT_DDC_CLK];
      blank_output_enable <= pwdata_in[`DTC_BIT_BLANK_EN];
      crt_horizontal_sync_enable <= pwdata_in[`DTC_BIT_HSYNC_EN];
      crt_vertical_sync_enable <= pwdata_in[`DTC_BIT_VSYNC_EN];
    end
  end

  // ==========================================================
  // Timing registers, writable only while stopped
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      h_active <= RST_H[`DTC_TIM_LO +: TW];
      h_total <= RST_H[`DTC_TIM_HI +: TW];
      h_sync_start <= RST_HS[`DTC_TIM_LO +: TW];
      h_sync_end <= RST_HS[`DTC_TIM_HI +: TW];
      v_active <= RST_V[`DTC_TIM_LO +: TW];
      v_total <= RST_V[`DTC_TIM_HI +: TW];
      v_sync_start <= RST_VS[`DTC_TIM_LO +: TW];
      v_sync_end <= RST_VS[`DTC_TIM_HI +: TW];
    end else if (timing_write_ok) begin
      case (paddr_in)
        `DTC_OFS_H_ACT_TOTAL: begin
          h_active <= pwdata_in[`DTC_TIM_LO +: TW];
          h_total <= pwdata_in[`DTC_TIM_HI +: TW];
        end
        `DTC_OFS_H_SYNC: begin
          h_sync_start <= pwdata_in[`DTC_TIM_LO +: TW];
          h_sync_end <= pwdata_in[`DTC_TIM_HI +: TW];
        end
        `DTC_OFS_V_ACT_TOTAL: begin
          v_active <= pwdata_in[`DTC_TIM_LO +: TW];
          v_total <= pwdata_in[`DTC_TIM_HI +: TW];
        end
        `DTC_OFS_V_SYNC: begin
          v_sync_start <= pwdata_in[`DTC_TIM_LO +: TW];
          v_sync_end <= pwdata_in[`DTC_TIM_HI +: TW];
        end
        default: h_active <= h_active;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status, set wins over write-one-clear
  wire vint_en_next = cfg_write ? pwdata_in[`DTC_BIT_VINT_EN] : vertical_interrupt_enable;
  wire [`DTC_INT_WIDTH-1:0] int_events;
  assign int_events[`DTC_INT_VERTICAL] = vsync_start && vertical_interrupt_enable;
  assign int_events[`DTC_INT_WRITE_REFUSED] = timing_write_refused;
  assign int_events[`DTC_INT_FRAME_END] = frame_end;

  always @* begin
    next_int_status = int_status;
    if (bus_write && (paddr_in == `DTC_OFS_INT_STATUS)) begin
      next_int_status = int_status & ~pwdata_in[`DTC_INT_WIDTH-1:0];
    end
    next_int_status = next_int_status | int_events;
    if (!vint_en_next) begin
      next_int_status[`DTC_INT_VERTICAL] = 1'b0;
    end
  end
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      int_status <= {`DTC_INT_WIDTH{1'b0}};
      int_mask <= `DTC_RST_INT_MASK;
    end else begin
      int_status <= next_int_status;
      if (bus_write && (paddr_in == `DTC_OFS_INT_MASK)) begin
        int_mask <= pwdata_in[`DTC_INT_WIDTH-1:0];
      end
    end
  end
  assign irq_out = |(int_status & int_mask);

  // ==========================================================
  // Blink frame counter
  always @(posedge ref_clk_in) begin
    if (rst_in || !timing_generator_enable) begin
      frame_cnt <= {`DTC_BLINK_CNT_W{1'b0}};
    end else if (frame_end) begin
      frame_cnt <= frame_cnt + {{(`DTC_BLINK_CNT_W-1){1'b0}}, 1'b1};
    end
  end
  // Rate 1 halves the blink rate of rate 0
  wire cursor_phase = blink_rate_select ? frame_cnt[`DTC_BLINK_CURSOR_BIT + 1] :
                      frame_cnt[`DTC_BLINK_CURSOR_BIT];
  wire text_phase = blink_rate_select ? frame_cnt[`DTC_BLINK_TEXT_BIT + 1] :
                    frame_cnt[`DTC_BLINK_TEXT_BIT];

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      cursor_blink_on_out <= 1'b1;
      text_blink_on_out <= 1'b1;
    end else begin
      cursor_blink_on_out <= !blink_enable_bit || !cursor_phase;
      text_blink_on_out <= !blink_enable_bit || !text_phase;
    end
  end

  // ==========================================================
  // Output pins
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      crt_vertical_sync_pin_out <= 1'b0;
      crt_horizontal_sync_pin_out <= 1'b0;
      panel_vsync_out <= 1'b0;
      panel_hsync_out <= 1'b0;
      display_enable_out <= 1'b0;
    end else begin
      if (crt_vertical_sync_enable) begin
        crt_vertical_sync_pin_out <= vsync_raw ^ crt_vertical_sync_polarity;
      end else begin
        crt_vertical_sync_pin_out <= data_channel_clock_bit;
      end
      if (crt_horizontal_sync_enable) begin
        crt_horizontal_sync_pin_out <= hsync_raw ^ crt_horizontal_sync_polarity;
      end else begin
        crt_horizontal_sync_pin_out <= 1'b0;
      end
      if (panel_sync_enable_in) begin
        panel_vsync_out <= vsync_raw ^ panel_vsync_polarity;
        panel_hsync_out <= hsync_raw ^ panel_hsync_polarity;
      end else begin
        panel_vsync_out <= 1'b0;
        panel_hsync_out <= 1'b0;
      end
      display_enable_out <= blank_output_enable && active_raw;
    end
  end

  // ==========================================================
  // Data channel input capture
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ddc_in_q <= 1'b0;
    end else begin
      ddc_in_q <= data_channel_in;
    end
  end

  // ==========================================================
  // Read data
  always @* begin
    prdata_out = 32'h0000_0000;
    if (bus_access && !pwrite_in) begin
      case (paddr_in)
        `DTC_OFS_CONFIG: begin
          prdata_out[`DTC_BIT_BLINK_RATE] = blink_rate_select;
          prdata_out[`DTC_BIT_PANEL_VSP] = panel_vsync_polarity;
          prdata_out[`DTC_BIT_PANEL_HSP] = panel_hsync_polarity;
          prdata_out[`DTC_BIT_CRT_VSP] = crt_vertical_sync_polarity;
          prdata_out[`DTC_BIT_CRT_HSP] = crt_horizontal_sync_polarity;
          prdata_out[`DTC_BIT_BLINK_EN] = blink_enable_bit;
          prdata_out[`DTC_BIT_VINT_EN] = vertical_interrupt_enable;
          prdata_out[`DTC_BIT_TIMING_GENERATOR_ENABLE] = timing_generator_enable;
          prdata_out[`DTC_BIT_DDC_CLK] = data_channel_clock_bit;
          prdata_out[`DTC_BIT_BLANK_EN] = blank_output_enable;
          prdata_out[`DTC_BIT_HSYNC_EN] = crt_horizontal_sync_enable;
          prdata_out[`DTC_BIT_VSYNC_EN] = crt_vertical_sync_enable;
        end
        `DTC_OFS_INT_STATUS: begin
          prdata_out[`DTC_INT_WIDTH-1:0] = int_status;
        end
        `DTC_OFS_INT_MASK: begin
          prdata_out[`DTC_INT_WIDTH-1:0] = int_mask;
        end
        `DTC_OFS_STATUS: begin
          prdata_out[`DTC_STS_DDC_IN] = ddc_in_q;
          prdata_out[`DTC_STS_RUNNING] = timing_generator_enable;
          prdata_out[`DTC_STS_ACTIVE] = active_raw;
          prdata_out[`DTC_STS_CURSOR_ON] = cursor_blink_on_out;
          prdata_out[`DTC_STS_TEXT_ON] = text_blink_on_out;
        end
        `DTC_OFS_H_ACT_TOTAL: begin
          prdata_out[`DTC_TIM_LO +: TW] = h_active;
          prdata_out[`DTC_TIM_HI +: TW] = h_total;
        end
        `DTC_OFS_H_SYNC: begin
          prdata_out[`DTC_TIM_LO +: TW] = h_sync_start;
          prdata_out[`DTC_TIM_HI +: TW] = h_sync_end;
        end
        `DTC_OFS_V_ACT_TOTAL: begin
          prdata_out[`DTC_TIM_LO +: TW] = v_active;
          prdata_out[`DTC_TIM_HI +: TW] = v_total;
        end
        `DTC_OFS_V_SYNC: begin
          prdata_out[`DTC_TIM_LO +: TW] = v_sync_start;
          prdata_out[`DTC_TIM_HI +: TW] = v_sync_end;
        end
        default: prdata_out = 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### logic/dtc_regs.vh
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// ==========================================================
// Register offsets
`define DTC_OFS_CONFIG 12'h000
`define DTC_OFS_INT_STATUS 12'h004
`define DTC_OFS_INT_MASK 12'h008
`define DTC_OFS_STATUS 12'h00C
`define DTC_OFS_H_ACT_TOTAL 12'h010
`define DTC_OFS_H_SYNC 12'h014
`define DTC_OFS_V_ACT_TOTAL 12'h018
`define DTC_OFS_V_SYNC 12'h01C

// ==========================================================
// Configuration field positions
`define DTC_BIT_BLINK_RATE 16
`define DTC_BIT_PANEL_VSP 11
`define DTC_BIT_PANEL_HSP 10
`define DTC_BIT_CRT_VSP 9
`define DTC_BIT_CRT_HSP 8
`define DTC_BIT_BLINK_EN 7
`define DTC_BIT_VINT_EN 6
`define DTC_BIT_TIMING_GENERATOR_ENABLE 5
`define DTC_BIT_DDC_CLK 4
`define DTC_BIT_BLANK_EN 3
`define DTC_BIT_HSYNC_EN 2
`define DTC_BIT_VSYNC_EN 1

// ==========================================================
// Interrupt status bits
`define DTC_INT_VERTICAL 0
`define DTC_INT_WRITE_REFUSED 1
`define DTC_INT_FRAME_END 2
`define DTC_INT_WIDTH 3

// ==========================================================
// Status bits
`define DTC_STS_DDC_IN 0
`define DTC_STS_RUNNING 1
`define DTC_STS_ACTIVE 2
`define DTC_STS_CURSOR_ON 3
`define DTC_STS_TEXT_ON 4

// ==========================================================
// Timing field positions
`define DTC_TIM_LO 0
`define DTC_TIM_HI 16

// ==========================================================
// Reset values
`define DTC_RST_CONFIG 32'h0000_0000
`define DTC_RST_INT_MASK 3'h0
`define DTC_RST_H_ACT_TOTAL 32'h031F_027F
`define DTC_RST_H_SYNC 32'h02EF_028F
`define DTC_RST_V_ACT_TOTAL 32'h020C_01DF
`define DTC_RST_V_SYNC 32'h01EB_01E9

// ==========================================================
// Blink counts in frames
`define DTC_BLINK_CURSOR_BIT 3
`define DTC_BLINK_TEXT_BIT 4
`define DTC_BLINK_CNT_W 6

`endif

// ### logic/dtc_timing_gen.v
`timescale 1ns/100ps
`include "dtc_regs.vh"

module dtc_timing_gen #(
  parameter TW = 12
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire dot_en_in,
  input wire run_in,
  input wire [TW-1:0] h_active_in,
  input wire [TW-1:0] h_total_in,
  input wire [TW-1:0] h_sync_start_in,
  input wire [TW-1:0] h_sync_end_in,
  input wire [TW-1:0] v_active_in,
  input wire [TW-1:0] v_total_in,
  input wire [TW-1:0] v_sync_start_in,
  input wire [TW-1:0] v_sync_end_in,
  output reg hsync_out,
  output reg vsync_out,
  output reg active_out,
  output reg vsync_start_out,
  output reg frame_end_out
);

  // ==========================================================
  // Dot counters, held in reset while stopped
  reg [TW-1:0] h_cnt;
  reg [TW-1:0] v_cnt;
  wire h_last = (h_cnt == h_total_in);
  wire v_last = (v_cnt == v_total_in);
  wire next_vsync = (v_cnt >= v_sync_start_in) && (v_cnt < v_sync_end_in);

  always @(posedge ref_clk_in) begin
    if (rst_in || !run_in) begin
      h_cnt <= {TW{1'b0}};
      v_cnt <= {TW{1'b0}};
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      active_out <= 1'b0;
      vsync_start_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      vsync_start_out <= 1'b0;
      frame_end_out <= 1'b0;
      if (dot_en_in) begin
        h_cnt <= h_last ? {TW{1'b0}} : h_cnt + {{(TW-1){1'b0}}, 1'b1};
        if (h_last) begin
          v_cnt <= v_last ? {TW{1'b0}} : v_cnt + {{(TW-1){1'b0}}, 1'b1};
        end
        hsync_out <= (h_cnt >= h_sync_start_in) && (h_cnt < h_sync_end_in);
        vsync_out <= next_vsync;
        active_out <= (h_cnt <= h_active_in) && (v_cnt <= v_active_in);
        vsync_start_out <= next_vsync && !vsync_out;
        frame_end_out <= h_last && v_last;
      end
    end
  end

endmodule

// ### testbench/dtc_control_monitor.sv
`timescale 1ns/100ps
module dtc_control_monitor #(
  parameter TW = 12,
  parameter DOT_DIV = 4
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  input wire data_channel_in,
  input wire panel_sync_enable_in,
  input wire crt_vertical_sync_pin_out,
  input wire crt_horizontal_sync_pin_out,
  input wire panel_vsync_out,
  input wire panel_hsync_out,
  input wire display_enable_out,
  input wire cursor_blink_on_out,
  input wire text_blink_on_out,
  input wire irq_out
);
  // ==========================================================
  // Shadow of written control state
  reg [31:0] cfg;
  reg [31:0] cfg_d;
  reg [2:0] mask;
  reg pe_d;
  reg [1:0] stop_n;
  wire wr = psel_in & penable_in & pwrite_in;
  wire st = stop_n == 2'h3;
  always @(posedge ref_clk_in) begin
    cfg_d <= cfg;
    pe_d <= panel_sync_enable_in;
    if (rst_in) begin
      cfg <= 32'h0000_0000;
      mask <= 3'h0;
      stop_n <= 2'h0;
    end else begin
      if (wr && paddr_in == 12'h000)
        cfg <= pwdata_in;
      if (wr && paddr_in == 12'h008)
        mask <= pwdata_in[2:0];
      if (cfg[5])
        stop_n <= 2'h0;
      else if (!st)
        stop_n <= stop_n + 2'h1;
    end
  end
  // ==========================================================
  // Checks
  default clocking dcb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cfg_wr;
    wr && paddr_in == 12'h000;
  endsequence
  sequence s_tim_wr;
    wr && paddr_in[11:4] == 8'h01 && paddr_in[1:0] == 2'h0;
  endsequence
  chk_hsync_off_low: assert property (!cfg_d[2] |-> !crt_horizontal_sync_pin_out)
    else $error("crt_horizontal_sync_pin not low while off");
  chk_vsync_route: assert property (!cfg_d[1] |-> crt_vertical_sync_pin_out == cfg_d[4])
    else $error("crt_vertical_sync_pin pin not showing channel clock");
  chk_blank_off_low: assert property (!cfg_d[3] |-> !display_enable_out)
    else $error("display enable not low while off");
  chk_stop_crt_idle: assert property (st |->
    crt_horizontal_sync_pin_out == (cfg_d[2] & cfg_d[8]) &&
    (!cfg_d[1] || crt_vertical_sync_pin_out == cfg_d[9]))
    else $error("crt sync not idle while stopped");
  chk_stop_panel_idle: assert property (st |-> !display_enable_out &&
    panel_vsync_out == (pe_d & cfg_d[11]) && panel_hsync_out == (pe_d & cfg_d[10]))
    else $error("panel sync not idle while stopped");
  chk_blink_off_vis: assert property (!cfg_d[7] |-> cursor_blink_on_out && text_blink_on_out)
    else $error("blink output low while blink off");
  chk_timing_refused: assert property (s_tim_wr ##0 cfg[5] |-> pslverr_out)
    else $error("timing write not refused while running");
  chk_vint_clear: assert property (s_cfg_wr ##0 (!pwdata_in[6] && mask == 3'h1) |=> !irq_out)
    else $error("vertical interrupt kept after disable");
  chk_vint_source: assert property ($rose(irq_out) && $stable(mask) && mask == 3'h1 &&
    cfg_d[1] && !cfg_d[9] |-> cfg[6] ##[0:2] crt_vertical_sync_pin_out)
    else $error("vertical interrupt without sync pulse");
endmodule

bind dtc_control dtc_control_monitor #(.TW(TW), .DOT_DIV(DOT_DIV)) u_dtc_mon (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out), .data_channel_in(data_channel_in),
  .panel_sync_enable_in(panel_sync_enable_in),
  .crt_vertical_sync_pin_out(crt_vertical_sync_pin_out),
  .crt_horizontal_sync_pin_out(crt_horizontal_sync_pin_out),
  .panel_vsync_out(panel_vsync_out), .panel_hsync_out(panel_hsync_out),
  .display_enable_out(display_enable_out), .cursor_blink_on_out(cursor_blink_on_out),
  .text_blink_on_out(text_blink_on_out), .irq_out(irq_out));

// ### testbench/dtc_crt_model.sv
`timescale 1ns/100ps
module dtc_crt_model #(
  parameter logic [15:0] ID_WORD = 16'hC35A
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic vclk_in,
  output logic data_out
);
  logic vclk_q;
  logic [3:0] idx;
  // Next id bit on each rising channel clock, msb first
  always @(posedge clk_in) begin
    vclk_q <= vclk_in;
    if (rst_in) begin
      idx <= 4'hF;
      data_out <= 1'b1;
    end else if (vclk_in && !vclk_q) begin
      data_out <= ID_WORD[idx];
      idx <= idx - 4'h1;
    end
  end
endmodule

// ### testbench/tb_display_timing_control_bits.sv
`timescale 1ns/100ps
`include "dtc_regs.vh"
module tb_display_timing_control_bits;
  localparam logic [15:0] DDC_WORD = 16'hC35A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic pse = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] rd;
  logic [6:0] ex;
  logic err, cb_q, tb_q;
  wire ddc, ch, cv, ph, pv, de, cb, tb, irq, rdy, serr;
  wire [31:0] prd;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int c;
  int ereg [8];
  int n [5];
  logic [31:0] tim [4] = '{32'h000F_0007, 32'h000C_0009, 32'h000B_0005, 32'h0009_0007};

  dtc_control #(.DOT_DIV(1)) dut (
    .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .pready_out(rdy), .prdata_out(prd), .pslverr_out(serr),
    .data_channel_in(ddc), .panel_sync_enable_in(pse), .crt_vertical_sync_pin_out(cv),
    .crt_horizontal_sync_pin_out(ch), .panel_vsync_out(pv), .panel_hsync_out(ph),
    .display_enable_out(de), .cursor_blink_on_out(cb), .text_blink_on_out(tb), .irq_out(irq));
  dtc_crt_model #(.ID_WORD(DDC_WORD)) u_crt (.clk_in(clk), .rst_in(rst), .vclk_in(cv),
    .data_out(ddc));

  initial forever #5 clk = ~clk;

  // ==========================================================
  // Bus tasks and reference model
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic no;
    no = a[11:4] == 8'h01 && ereg[0][5];
    apb(1'b1, a, d);
    check({31'h0, err}, {31'h0, no || a > 12'h01C});
    if (a == 12'h000) ereg[0] = d & 32'h0001_0FFE;
    if (a == 12'h000 && !d[6]) ereg[1] = ereg[1] & ~1;
    if (a == 12'h004) ereg[1] = ereg[1] & ~d;
    if (a == 12'h008) ereg[2] = d & 32'h7;
    if (a[11:4] == 8'h01 && !no) ereg[a[3:2] + 4] = d & 32'h0FFF_0FFF;
    if (no) ereg[1] = ereg[1] | 2;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check({31'h0, err}, {31'h0, a > 12'h01C});
    check(rd & m, (a > 12'h01C ? 0 : ereg[a[4:2]]) & m);
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    ereg[1] = ereg[1] | 1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    void'($urandom(37651));
    ereg = '{`DTC_RST_CONFIG, 0, 0, 0, `DTC_RST_H_ACT_TOTAL, `DTC_RST_H_SYNC,
      `DTC_RST_V_ACT_TOTAL, `DTC_RST_V_SYNC};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 48; a += 4) if (a != 12) rd_chk(a[11:0], 32'hFFFF_FFFF);
    wr(12'h040, 32'h1);
    for (int i = 0; i < 4; i++) wr(12'h010 + 12'(4 * i), tim[i]);
    for (int a = 16; a < 32; a += 4) rd_chk(a[11:0], 32'hFFFF_FFFF);
    $display("map and timing write test done");
    repeat (8) begin
      c = $urandom;
      wr(12'h000, c & 32'h0F9E);
      pse <= c[0];
      repeat (4) @(posedge clk);
      ex = {c[2] & c[8], c[1] ? c[9] : c[4], c[0] & c[10], c[0] & c[11], 3'b011};
      check({25'h0, ch, cv, ph, pv, de, cb, tb}, {25'h0, ex});
    end
    $display("static level test done");
    for (int p = 0; p < 2; p++) begin
      pse <= 1'b1;
      wr(12'h000, p ? 32'h0F2E : 32'h002E);
      repeat (400) @(posedge clk);
      n = '{0, 0, 0, 0, 0};
      repeat (192) begin
        @(posedge clk);
        n[0] += ch != p[0];
        n[1] += cv != p[0];
        n[2] += ph != p[0];
        n[3] += pv != p[0];
        n[4] += de;
      end
      check(n[0], 36);
      check(n[1], 32);
      check(n[2], 36);
      check(n[3], 32);
      check(n[4], 48);
    end
    wr(12'h010, 32'h0005_0003);
    rd_chk(12'h010, 32'hFFFF_FFFF);
    rd_chk(12'h004, 32'h2);
    wr(12'h004, 32'h2);
    rd_chk(12'h004, 32'h2);
    $display("running sync test done");
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h006E);
    wait_irq();
    rd_chk(12'h004, 32'h1);
    wr(12'h008, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(12'h008, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(12'h004, 32'h1);
    check({31'h0, irq}, 32'h0);
    wait_irq();
    wr(12'h000, 32'h002E);
    check({31'h0, irq}, 32'h0);
    rd_chk(12'h004, 32'h1);
    repeat (400) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    for (int r = 0; r < 2; r++) begin
      wr(12'h000, 32'h00AE | (r << 16));
      repeat (800) @(posedge clk);
      n = '{0, 0, 0, 0, 0};
      cb_q = cb;
      tb_q = tb;
      repeat (12288) begin
        @(posedge clk);
        n[0] += cb != cb_q;
        n[1] += tb != tb_q;
        cb_q = cb;
        tb_q = tb;
      end
      check(n[0], 8 >> r);
      check(n[1], 4 >> r);
    end
    $display("blink test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({24'h0, irq, ch, cv, ph, pv, de, cb, tb}, 32'h3);
    wr(12'h000, 32'h0);
    for (int k = 15; k >= 0; k--) begin
      wr(12'h000, 32'h10);
      wr(12'h000, 32'h0);
      ereg[3] = DDC_WORD[k];
      rd_chk(12'h00C, 32'h1);
    end
    $display("data channel test done");
    tally_and_finish();
  end
endmodule
